// [hw/mtrap_map.svh]
`ifndef MTRAP_MAP_SVH
`define MTRAP_MAP_SVH

// Register byte offsets
`define MT_OFF_CTRL        12'h000
`define MT_OFF_IRQ_STATUS  12'h004
`define MT_OFF_IRQ_MASK    12'h008

// trap_control_one field positions
`define MT_BIT_CAT_A_FLAG  12
`define MT_BIT_CAT_B_FLAG  11
`define MT_BIT_OVF_A_EN    10
`define MT_BIT_OVF_B_EN    9
`define MT_BIT_CAT_EN      8
`define MT_BIT_SHIFT_FLAG  7
`define MT_BIT_DIV0_FLAG   6

// Interrupt status and mask field positions
`define MT_IRQ_CAT_A       0
`define MT_IRQ_CAT_B       1
`define MT_IRQ_OVF_A       2
`define MT_IRQ_OVF_B       3
`define MT_IRQ_SHIFT       4
`define MT_IRQ_DIV0        5

// Widths and reset values
`define MT_REG_W           16
`define MT_IRQ_W           6
`define MT_FLAG_W          4
`define MT_CTRL_RST        16'h0000
`define MT_IRQ_RST         6'h00
`define MT_FLAG_RST        4'h0
`define MT_DATA_W          32

`endif

// [hw/mtrap_pkg.sv]
package mtrap_pkg;

	// Arithmetic datapath event pulses
	typedef struct packed
	{
		logic cat_a;
		logic cat_b;
		logic ovf_a;
		logic ovf_b;
		logic bad_shift;
		logic div_zero;
	} mtrap_evt_t;

	// Trap requests toward the vectoring logic
	typedef struct packed
	{
		logic math_trap;
		logic cat_a;
		logic cat_b;
		logic ovf_a;
		logic ovf_b;
		logic bad_shift;
		logic div_zero;
	} mtrap_req_t;

endpackage

// [hw/mtrap_sticky.sv]
`timescale 1ns/100ps
`include "mtrap_map.svh"
module mtrap_sticky
	import mtrap_pkg::*;
#(
	parameter int          W     = 4,
	parameter bit          W1C   = 1'b0,
	parameter logic [W-1:0] RST  = '0
)
(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] set,
	input  wire logic         wr,
	input  wire logic [W-1:0] wdata,
	output logic      [W-1:0] q
);

	if (W < 1)
	begin : g_bad_w
		$error("mtrap_sticky: W must be at least 1");
	end

	// Hardware set wins over any software write in the same cycle
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					q[i] <= RST[i];
				else if (set[i])
					q[i] <= 1'b1;
				else if (wr)
					q[i] <= W1C ? (q[i] & ~wdata[i]) : wdata[i];
			end
		end
	endgenerate

endmodule

// [hw/mtrap_ctrl.sv]
// What this block does
// - Bit 12 is set when a trap comes from catastrophic overflow of accumulator A, else stays clear.
// - Bit 11 is set when a trap comes from catastrophic overflow of accumulator B, else stays clear.
// - Bit 10 at one lets ordinary overflow of accumulator A trap; at zero that trap is suppressed.
// - Bit 9 at one lets ordinary overflow of accumulator B trap; at zero that trap is suppressed.
// - Bit 8 at one lets catastrophic overflow of A or B trap; at zero those traps are disabled.
// - Bit 7 is set when a math trap comes from an invalid accumulator shift, else stays clear.
// - Bit 6 is set when a math trap comes from a divide by zero, else stays clear.
`timescale 1ns/100ps
`include "mtrap_map.svh"
module mtrap_ctrl
	import mtrap_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata_q,
	output logic                   pready_q,
	output logic                   pslverr_q,
	input  wire mtrap_evt_t        evt,
	output mtrap_req_t             trap_q,
	output logic                   irq_q
);

	if (ADDR_W < 4)
	begin : g_bad_addr_w
		$error("mtrap_ctrl: ADDR_W must be at least 4");
	end

	localparam logic [`MT_REG_W-1:0] CTRL_RST = `MT_CTRL_RST;

	logic [`MT_FLAG_W-1:0] flag_q;
	logic [`MT_FLAG_W-1:0] flag_set;
	logic [`MT_FLAG_W-1:0] flag_wdata;
	logic [`MT_IRQ_W-1:0]  irq_stat_q;
	logic [`MT_IRQ_W-1:0]  irq_mask_q;
	logic [`MT_IRQ_W-1:0]  irq_set;
	logic                  ovf_a_en_q;
	logic                  ovf_b_en_q;
	logic                  cat_en_q;
	logic                  cat_a_trap;
	logic                  cat_b_trap;
	logic                  ovf_a_trap;
	logic                  ovf_b_trap;
	logic                  any_trap;
	logic                  acc_done;
	logic                  wr_ctrl;
	logic                  wr_stat;
	logic                  wr_mask;
	logic [`MT_REG_W-1:0]  ctrl_view;
	logic [11:0]           off;

	function automatic logic addr_is(input logic [11:0] a, input logic [11:0] o);
		addr_is = (a == o);
	endfunction

	function automatic logic addr_mapped(input logic [11:0] a);
		addr_mapped = addr_is(a, `MT_OFF_CTRL) || addr_is(a, `MT_OFF_IRQ_STATUS)
			|| addr_is(a, `MT_OFF_IRQ_MASK);
	endfunction

	assign off = 12'(paddr);

	// Trap qualification
	assign cat_a_trap = evt.cat_a & cat_en_q;
	assign cat_b_trap = evt.cat_b & cat_en_q;
	assign ovf_a_trap = evt.ovf_a & ovf_a_en_q;
	assign ovf_b_trap = evt.ovf_b & ovf_b_en_q;
	assign any_trap   = cat_a_trap | cat_b_trap | ovf_a_trap | ovf_b_trap
		| evt.bad_shift | evt.div_zero;

	// APB access completes at the edge where pready is high
	assign acc_done = psel & penable & pready_q;
	assign wr_ctrl  = acc_done & pwrite & addr_is(off, `MT_OFF_CTRL);
	assign wr_stat  = acc_done & pwrite & addr_is(off, `MT_OFF_IRQ_STATUS);
	assign wr_mask  = acc_done & pwrite & addr_is(off, `MT_OFF_IRQ_MASK);

	// Flag order: cat_a, cat_b, shift, div0
	assign flag_set[3] = cat_a_trap;
	assign flag_set[2] = cat_b_trap;
	assign flag_set[1] = evt.bad_shift;
	assign flag_set[0] = evt.div_zero;

	assign flag_wdata = {pwdata[`MT_BIT_CAT_A_FLAG], pwdata[`MT_BIT_CAT_B_FLAG],
		pwdata[`MT_BIT_SHIFT_FLAG], pwdata[`MT_BIT_DIV0_FLAG]};

	// Cause flags hold until software writes them
	mtrap_sticky #(
		.W   (`MT_FLAG_W),
		.W1C (1'b0),
		.RST (`MT_FLAG_RST)
	) u_flags (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (flag_set),
		.wr      (wr_ctrl),
		.wdata   (flag_wdata),
		.q       (flag_q)
	);

	always_comb
	begin
		irq_set = '0;
		irq_set[`MT_IRQ_CAT_A] = cat_a_trap;
		irq_set[`MT_IRQ_CAT_B] = cat_b_trap;
		irq_set[`MT_IRQ_OVF_A] = ovf_a_trap;
		irq_set[`MT_IRQ_OVF_B] = ovf_b_trap;
		irq_set[`MT_IRQ_SHIFT] = evt.bad_shift;
		irq_set[`MT_IRQ_DIV0]  = evt.div_zero;
	end

	mtrap_sticky #(
		.W   (`MT_IRQ_W),
		.W1C (1'b1),
		.RST (`MT_IRQ_RST)
	) u_irq_stat (
		.pclk    (pclk),
		.presetn (presetn),
		.set     (irq_set),
		.wr      (wr_stat),
		.wdata   (pwdata[`MT_IRQ_W-1:0]),
		.q       (irq_stat_q)
	);

	// Trap enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ovf_a_en_q <= CTRL_RST[`MT_BIT_OVF_A_EN];
			ovf_b_en_q <= CTRL_RST[`MT_BIT_OVF_B_EN];
			cat_en_q   <= CTRL_RST[`MT_BIT_CAT_EN];
		end
		else if (wr_ctrl)
		begin
			ovf_a_en_q <= pwdata[`MT_BIT_OVF_A_EN];
			ovf_b_en_q <= pwdata[`MT_BIT_OVF_B_EN];
			cat_en_q   <= pwdata[`MT_BIT_CAT_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_q <= `MT_IRQ_RST;
		else if (wr_mask)
			irq_mask_q <= pwdata[`MT_IRQ_W-1:0];
	end

	always_comb
	begin
		ctrl_view = `MT_CTRL_RST;
		ctrl_view[`MT_BIT_CAT_A_FLAG] = flag_q[3];
		ctrl_view[`MT_BIT_CAT_B_FLAG] = flag_q[2];
		ctrl_view[`MT_BIT_OVF_A_EN]   = ovf_a_en_q;
		ctrl_view[`MT_BIT_OVF_B_EN]   = ovf_b_en_q;
		ctrl_view[`MT_BIT_CAT_EN]     = cat_en_q;
		ctrl_view[`MT_BIT_SHIFT_FLAG] = flag_q[1];
		ctrl_view[`MT_BIT_DIV0_FLAG]  = flag_q[0];
	end

	// One wait state: ready rises at the edge that ends the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q  <= 1'b1;
			pslverr_q <= !addr_mapped(off);
			prdata_q  <= 32'h0000_0000;
			if (!pwrite)
			begin
				if (addr_is(off, `MT_OFF_CTRL))
					prdata_q <= {16'h0000, ctrl_view};
				else if (addr_is(off, `MT_OFF_IRQ_STATUS))
					prdata_q <= {26'h0000000, irq_stat_q};
				else if (addr_is(off, `MT_OFF_IRQ_MASK))
					prdata_q <= {26'h0000000, irq_mask_q};
			end
		end
		else
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Trap requests, one cycle after the event
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trap_q <= '0;
		else
		begin
			trap_q.math_trap <= any_trap;
			trap_q.cat_a     <= cat_a_trap;
			trap_q.cat_b     <= cat_b_trap;
			trap_q.ovf_a     <= ovf_a_trap;
			trap_q.ovf_b     <= ovf_b_trap;
			trap_q.bad_shift <= evt.bad_shift;
			trap_q.div_zero  <= evt.div_zero;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(irq_stat_q & irq_mask_q);
	end

	AST_CAT_A_SET: assert property (@(posedge pclk) disable iff (!presetn)
		evt.cat_a && cat_en_q |=> ctrl_view[`MT_BIT_CAT_A_FLAG] && trap_q.math_trap)
		else $error("cat A overflow did not set its flag");

	AST_CAT_B_SET: assert property (@(posedge pclk) disable iff (!presetn)
		evt.cat_b && cat_en_q |=> ctrl_view[`MT_BIT_CAT_B_FLAG] && trap_q.cat_b)
		else $error("cat B overflow did not set its flag");

	AST_CAT_A_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_view[`MT_BIT_CAT_A_FLAG] && !cat_en_q && !wr_ctrl
		|=> !ctrl_view[`MT_BIT_CAT_A_FLAG])
		else $error("cat A flag rose without an enabled trap");

	AST_OVF_A_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		evt.ovf_a |=> trap_q.ovf_a == $past(ovf_a_en_q))
		else $error("overflow A trap not gated by its enable");

	AST_OVF_B_GATE: assert property (@(posedge pclk) disable iff (!presetn)
		evt.ovf_b && !ovf_b_en_q |=> !trap_q.ovf_b)
		else $error("overflow B trap not suppressed");

	AST_CAT_OFF: assert property (@(posedge pclk) disable iff (!presetn)
		!cat_en_q |=> !trap_q.cat_a && !trap_q.cat_b)
		else $error("catastrophic trap passed while disabled");

	AST_SHIFT_SET: assert property (@(posedge pclk) disable iff (!presetn)
		evt.bad_shift |=> ctrl_view[`MT_BIT_SHIFT_FLAG] && trap_q.math_trap)
		else $error("bad shift did not set its flag");

	AST_DIV0_SET: assert property (@(posedge pclk) disable iff (!presetn)
		evt.div_zero |=> ctrl_view[`MT_BIT_DIV0_FLAG] ##1 ctrl_view[`MT_BIT_DIV0_FLAG] || $past(wr_ctrl))
		else $error("divide by zero did not set its flag");

	AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_view[`MT_BIT_SHIFT_FLAG] && !wr_ctrl |=> ctrl_view[`MT_BIT_SHIFT_FLAG])
		else $error("cause flag dropped without a write");

	AST_APB_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable ##1 psel && penable |-> !pready_q ##1 pready_q)
		else $error("APB answer not after one wait state");

	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		|(irq_stat_q & irq_mask_q) |=> irq_q)
		else $error("interrupt not raised for unmasked status");

	AST_CAT_A_TRAP: assert property (@(posedge pclk) disable iff (!presetn)
		evt.cat_a && cat_en_q |=> trap_q.cat_a)
		else $error("enabled cat A overflow gave no trap");

	AST_CAT_B_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_view[`MT_BIT_CAT_B_FLAG] && !cat_en_q && !wr_ctrl
		|=> !ctrl_view[`MT_BIT_CAT_B_FLAG])
		else $error("cat B flag rose without an enabled trap");

	AST_OVF_A_PASS: assert property (@(posedge pclk) disable iff (!presetn)
		evt.ovf_a && ovf_a_en_q |=> trap_q.ovf_a && trap_q.math_trap)
		else $error("enabled overflow A gave no trap");

	AST_OVF_B_PASS: assert property (@(posedge pclk) disable iff (!presetn)
		evt.ovf_b && ovf_b_en_q |=> trap_q.ovf_b && trap_q.math_trap)
		else $error("enabled overflow B gave no trap");

	AST_OVF_A_EN_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> ovf_a_en_q == $past(pwdata[`MT_BIT_OVF_A_EN]))
		else $error("overflow A enable not taken from the write");

	AST_CAT_EN_WR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl |=> cat_en_q == $past(pwdata[`MT_BIT_CAT_EN]))
		else $error("catastrophic enable not taken from the write");

	AST_SHIFT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_view[`MT_BIT_SHIFT_FLAG] && !evt.bad_shift && !wr_ctrl
		|=> !ctrl_view[`MT_BIT_SHIFT_FLAG])
		else $error("bad shift flag rose without an event");

	AST_DIV0_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_view[`MT_BIT_DIV0_FLAG] && !evt.div_zero && !wr_ctrl
		|=> !ctrl_view[`MT_BIT_DIV0_FLAG])
		else $error("divide by zero flag rose without an event");

	AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
		wr_ctrl && !pwdata[`MT_BIT_DIV0_FLAG] && !evt.div_zero
		|=> !ctrl_view[`MT_BIT_DIV0_FLAG])
		else $error("cause flag not cleared by software write");

	AST_TRAP_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		evt == '0 |=> trap_q == '0)
		else $error("trap request without an event");

endmodule

// [dv/mtrap_dp_model.sv]
`timescale 1ns/100ps
module mtrap_dp_model
	import mtrap_pkg::*;
(
	input  wire logic pclk,
	output mtrap_evt_t evt
);
	initial evt = '0;

	// One event cycle, then a quiet cycle; call just after a rising edge
	task automatic fire(input mtrap_evt_t e);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
		@(posedge pclk);
	endtask
endmodule

// [dv/mtrap_ctrl_tb_top.sv]
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value %s exp %h got %h", nm, e, a); end end
module mtrap_ctrl_tb_top
	import mtrap_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, irq_q, pready_q, pslverr_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata_q;
	mtrap_evt_t  evt;
	mtrap_req_t  trap_q;
	int          fail_count, n_checks, cyc, i, sd;
	logic [32:0] rq[$];
	logic [6:0]  tq[$];
	logic [32:0] rtmp;
	logic [6:0]  ttmp;
	logic [15:0] en;
	logic [5:0]  ev, q, st;

	mtrap_ctrl mtrap_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
		.pready_q(pready_q), .pslverr_q(pslverr_q), .evt(evt), .trap_q(trap_q), .irq_q(irq_q));
	mtrap_dp_model mtrap_dp_model_i (.pclk(pclk), .evt(evt));

	always #5 pclk = ~pclk;

	task automatic print_verdict();
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Reads note {pslverr, data} as the expected answer
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		if (!w)
			rq.push_back(exp);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready_q !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	always @(posedge pclk)
	begin
		cyc++;
		if (psel && penable && pready_q === 1'b1 && !pwrite)
		begin
			rtmp = (rq.size() > 0) ? rq.pop_front() : 33'h1ffffffff;
			`CHK("read", rtmp, {pslverr_q, prdata_q})
		end
		if (presetn && trap_q !== 7'h00)
		begin
			ttmp = (tq.size() > 0) ? tq.pop_front() : 7'h00;
			`CHK("trap", ttmp, trap_q)
		end
		if (cyc == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end

	initial
	begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
		sd = $urandom(11988);
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(0, 12'h000, 32'h0, 33'h0);
		apb(0, 12'h00c, 32'h0, {1'b1, 32'h0});
		apb(1, 12'h008, 32'h3f, 33'h0);
		for (i = 0; i < 24; i++)
		begin
			en = (i == 0) ? 16'h0700 : (i == 1) ? 16'h0000 : 16'($urandom) & 16'h0700;
			ev = (i < 2) ? 6'h3f : 6'($urandom);
			apb(1, 12'h000, {16'h0, en}, 33'h0);
			apb(1, 12'h004, 32'h3f, 33'h0);
			q = {ev[5:4] & {2{en[8]}}, ev[3] & en[10], ev[2] & en[9], ev[1:0]};
			if (q != 6'h00)
				tq.push_back({1'b1, q});
			mtrap_dp_model_i.fire(ev);
			st = {q[0], q[1], q[2], q[3], q[4], q[5]};
			apb(0, 12'h000, 32'h0, {17'h0, en | {3'h0, q[5:4], 3'h0, q[1:0], 6'h0}});
			apb(0, 12'h000, 32'h0, {17'h0, en | {3'h0, q[5:4], 3'h0, q[1:0], 6'h0}});
			apb(0, 12'h004, 32'h0, {27'h0, st});
			`CHK("irq", |st, irq_q)
		end
		apb(1, 12'h008, 32'h0, 33'h0);
		apb(1, 12'h004, 32'h3f, 33'h0);
		tq.push_back(7'h41);
		mtrap_dp_model_i.fire(6'h01);
		apb(0, 12'h004, 32'h0, 33'h20);
		`CHK("irq masked", 1'b0, irq_q)
		apb(1, 12'h004, 32'h3f, 33'h0);
		apb(1, 12'h000, 32'h0, 33'h0);
		apb(0, 12'h000, 32'h0, 33'h0);
		`CHK("left", 0, rq.size() + tq.size())
		print_verdict();
	end
endmodule
